// [pata_rst_cfg.svh]
/*
 * Timing counts and bit positions for the reset sequencer.
 * Assumes ref_clk at 20 MHz (50 ns period).
 */
`ifndef PATA_RST_CFG_SVH
`define PATA_RST_CFG_SVH

// ==========================================================
// Clock
// ==========================================================
`define PRS_CLK_NS 50
// Ticks: one enable pulse per microsecond
`define PRS_US_NS 1000
`define PRS_US_DIV (`PRS_US_NS / `PRS_CLK_NS)

// ==========================================================
// Timing in microsecond ticks; release count PRS_REL_CYC in ref_clk cycles
// ==========================================================
`define PRS_DEV_CLR_MS 1
`define PRS_DEV_CLR_US (`PRS_DEV_CLR_MS * 1000)
`define PRS_DASP_MS 400
`define PRS_DASP_US (`PRS_DASP_MS * 1000)
`define PRS_DIAG1_S 30
`define PRS_DIAG1_US (`PRS_DIAG1_S * 1000000)
`define PRS_PDIAG_S 31
`define PRS_PDIAG_US (`PRS_PDIAG_S * 1000000)
`define PRS_REL_NS 400
`define PRS_REL_CYC (`PRS_REL_NS / `PRS_CLK_NS)

// ==========================================================
// Status and error bits
// ==========================================================
`define PRS_ST_BSY 7
`define PRS_ERR_D1FAIL 7
`define PRS_ST_NONPKT_CLR 8'h0D
`define PRS_ST_PKT_CLR 8'h7D
`define PRS_ERR_RST 8'h01
`define PRS_ST_RST 8'h00

`endif

// [pata_rst_pkg.sv]
/*
 * Types for the reset sequencer.
 * Assumes pata_rst_cfg.svh holds the numbers.
 */
package prs_pkg;
    typedef enum logic [3:0] {
        PRS_IDLE,
        PRS_HR_REL,
        PRS_HR_D0_WAIT,
        PRS_HR_D0_DASP,
        PRS_HR_D0_PDIAG,
        PRS_HR_D1_DASP,
        PRS_SR_HOLD,
        PRS_SR_D0_WAIT,
        PRS_SR_D0_PDIAG,
        PRS_SR_D1_REL,
        PRS_STATUS
    } prs_state_t;
endpackage

// [prs_tick.sv]
/*
 * Microsecond tick divider and elapsed-time counter.
 * Assumes one clock, synchronous reset; restart clears the count.
 */
`timescale 1ns/1ps
`include "pata_rst_cfg.svh"
module prs_tick #(
    parameter int DIV = `PRS_US_DIV
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic restart,
    output logic [25:0] elapsed_us
);
    logic [7:0] div_reg;
    wire tick = (div_reg == 8'(DIV - 1));

    // ==========================================================
    // Divider and elapsed counter
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (srst || restart) begin
            div_reg <= 8'h00;
            elapsed_us <= 26'h000_0000;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            if (tick && elapsed_us != 26'h3FF_FFFF) begin
                elapsed_us <= elapsed_us + 26'h000_0001;
            end
        end
    end
endmodule

// [prs_sync.sv]
/*
 * Three-flop pin synchroniser; output changes when stages two and three agree.
 * Assumes an asynchronous input and a synchronous reset.
 */
`timescale 1ns/1ps
module prs_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic pin,
    output logic level
);
    logic s1_reg, s2_reg, s3_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level <= INIT;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule

// [prs_seq.sv]
/*
 * Parallel ATA device reset sequencer: hardware reset tail and software reset.
 * Assumes the host keeps its own timing; diagnostics engine is outside and
 * reports through diag_done/diag_pass/diag_code.
 */
`timescale 1ns/1ps
`include "pata_rst_cfg.svh"
module prs_seq
    import prs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reset_n_pin,
    input wire logic is_dev1,
    input wire logic packet_dev,
    input wire logic srst_bit,
    input wire logic dev_reset_cmd,
    input wire logic dasp_n_in,
    input wire logic pdiag_n_in,
    input wire logic diag_done,
    input wire logic diag_pass,
    input wire logic [6:0] diag_code,
    input wire logic mode_saved,
    output logic bsy,
    output logic [7:0] status_clr,
    output logic [7:0] error_val,
    output logic error_load,
    output logic dev_bit_clr,
    output logic srst_bit_clr,
    output logic sig_load,
    output logic word93_set,
    output logic udma_disable,
    output logic defaults_revert,
    output logic modes_init,
    output logic mode_restore_saved,
    output logic mode_restore_default,
    output logic diag_start,
    output logic bus_release,
    output logic selected,
    output logic dev_reset_accept,
    output logic dasp_n_out,
    output logic dasp_n_oe,
    output logic pdiag_n_out,
    output logic pdiag_n_oe,
    output logic done
);
    prs_state_t state_reg, state_next;
    logic [25:0] elapsed_us;
    logic rst_n_s, rst_n_d_reg, srst_d_reg;
    logic dasp_n_s, pdiag_n_s;
    logic d1_seen_reg, d1_seen_next;
    logic err7_reg, err7_next;
    logic pdiag_drive_reg;
    logic sw_reg;
    logic [3:0] rel_cnt_reg;

    // ==========================================================
    // Pin synchronisers and timer
    // ==========================================================
    prs_sync #(.INIT(1'b1)) u_rst (.ref_clk(ref_clk), .srst(srst), .pin(reset_n_pin), .level(rst_n_s));
    prs_sync #(.INIT(1'b1)) u_dasp (.ref_clk(ref_clk), .srst(srst), .pin(dasp_n_in), .level(dasp_n_s));
    prs_sync #(.INIT(1'b1)) u_pdiag (.ref_clk(ref_clk), .srst(srst), .pin(pdiag_n_in), .level(pdiag_n_s));

    wire hw_in_reset = !rst_n_s;
    wire hw_release = rst_n_s && !rst_n_d_reg;
    wire srst_rise = srst_bit && !srst_d_reg;
    wire srst_fall = !srst_bit && srst_d_reg;
    wire timer_restart = hw_in_reset || hw_release || srst_bit || srst_fall;

    prs_tick u_tick (.ref_clk(ref_clk), .srst(srst), .restart(timer_restart), .elapsed_us(elapsed_us));

    wire t_1ms = (elapsed_us >= 26'(`PRS_DEV_CLR_US));
    wire t_31s = (elapsed_us >= 26'(`PRS_PDIAG_US));
    wire pdiag_seen = !pdiag_n_s;
    wire dasp_seen = !dasp_n_s;

    // ==========================================================
    // Sequence state machine
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        d1_seen_next = d1_seen_reg;
        err7_next = err7_reg;
        case (state_reg)
            PRS_IDLE: begin
                if (srst_bit) begin
                    state_next = PRS_SR_HOLD;
                end
            end
            PRS_HR_REL: begin
                state_next = is_dev1 ? PRS_HR_D1_DASP : PRS_HR_D0_WAIT;
                d1_seen_next = 1'b0;
            end
            PRS_HR_D0_WAIT: begin
                if (t_1ms) begin
                    state_next = PRS_HR_D0_DASP;
                end
            end
            PRS_HR_D0_DASP: begin
                if (dasp_seen) begin
                    d1_seen_next = 1'b1;
                    state_next = PRS_HR_D0_PDIAG;
                end else if (t_31s) begin
                    err7_next = 1'b0;
                    state_next = PRS_STATUS;
                end
            end
            PRS_HR_D0_PDIAG, PRS_SR_D0_PDIAG: begin
                if (pdiag_seen) begin
                    err7_next = 1'b0;
                    state_next = PRS_STATUS;
                end else if (t_31s) begin
                    err7_next = 1'b1;
                    state_next = PRS_STATUS;
                end
            end
            PRS_HR_D1_DASP: begin
                state_next = PRS_STATUS;
            end
            PRS_SR_HOLD: begin
                if (!srst_bit) begin
                    if (is_dev1) begin
                        state_next = PRS_SR_D1_REL;
                    end else if (d1_seen_reg) begin
                        state_next = PRS_SR_D0_WAIT;
                    end else begin
                        err7_next = 1'b0;
                        state_next = PRS_STATUS;
                    end
                end
            end
            PRS_SR_D0_WAIT: begin
                if (t_1ms) begin
                    state_next = PRS_SR_D0_PDIAG;
                end
            end
            PRS_SR_D1_REL: begin
                state_next = PRS_STATUS;
            end
            PRS_STATUS: begin
                if (diag_done) begin
                    state_next = PRS_IDLE;
                end
            end
            default: begin
                state_next = PRS_IDLE;
            end
        endcase
        if (sw_reg && srst_rise && state_reg != PRS_IDLE) begin
            state_next = PRS_SR_HOLD;
        end
        if (hw_in_reset) begin
            state_next = PRS_HR_REL;
        end
    end

    // ==========================================================
    // State registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= PRS_HR_REL;
            d1_seen_reg <= 1'b0;
            err7_reg <= 1'b0;
            rst_n_d_reg <= 1'b1;
            srst_d_reg <= 1'b0;
            sw_reg <= 1'b0;
            rel_cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            d1_seen_reg <= d1_seen_next;
            err7_reg <= err7_next;
            rst_n_d_reg <= rst_n_s;
            srst_d_reg <= srst_bit;
            if (state_next == PRS_HR_REL) begin
                sw_reg <= 1'b0;
            end else if (state_next == PRS_SR_HOLD) begin
                sw_reg <= 1'b1;
            end
            if (state_next != state_reg) begin
                rel_cnt_reg <= 4'h0;
            end else if (rel_cnt_reg != 4'(`PRS_REL_CYC)) begin
                rel_cnt_reg <= rel_cnt_reg + 4'h1;
            end
        end
    end

    // ==========================================================
    // PDIAG- drive for device 1
    // ==========================================================
    wire finish = (state_reg == PRS_STATUS) && diag_done;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pdiag_drive_reg <= 1'b0;
        end else if (state_reg == PRS_HR_REL || state_reg == PRS_SR_HOLD || state_reg == PRS_SR_D1_REL) begin
            pdiag_drive_reg <= 1'b0;
        end else if (finish && is_dev1) begin
            pdiag_drive_reg <= diag_pass;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    wire in_seq = (state_reg != PRS_IDLE);
    wire d1_hw = (state_reg == PRS_HR_D1_DASP);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bsy <= 1'b1;
            status_clr <= 8'h00;
            error_val <= 8'h00;
            error_load <= 1'b0;
            sig_load <= 1'b0;
            word93_set <= 1'b0;
            srst_bit_clr <= 1'b0;
            modes_init <= 1'b0;
            mode_restore_saved <= 1'b0;
            mode_restore_default <= 1'b0;
            selected <= 1'b0;
            dasp_n_oe <= 1'b0;
            done <= 1'b0;
        end else begin
            bsy <= (state_next != PRS_IDLE);
            done <= finish;
            error_load <= finish;
            error_val <= {is_dev1 ? 1'b0 : err7_next, diag_code};
            sig_load <= finish;
            word93_set <= finish && !sw_reg;
            srst_bit_clr <= finish && !sw_reg;
            status_clr <= finish ? (packet_dev ? `PRS_ST_PKT_CLR : `PRS_ST_NONPKT_CLR) : 8'h00;
            modes_init <= finish && packet_dev;
            mode_restore_saved <= finish && packet_dev && mode_saved;
            mode_restore_default <= finish && packet_dev && !mode_saved;
            if (finish) begin
                selected <= !is_dev1;
            end
            if (hw_in_reset) begin
                dasp_n_oe <= 1'b0;
            end else if (d1_hw) begin
                dasp_n_oe <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Combinational controls
    // ==========================================================
    assign dev_bit_clr = (state_reg == PRS_HR_REL) || (state_reg == PRS_SR_D0_WAIT)
        || (state_reg == PRS_SR_D1_REL) || d1_hw;
    assign udma_disable = (state_reg == PRS_HR_REL);
    assign defaults_revert = (state_reg == PRS_HR_REL) || (state_reg == PRS_SR_HOLD && !packet_dev);
    assign diag_start = (state_reg == PRS_HR_REL) || (state_reg == PRS_SR_HOLD && !packet_dev && srst_d_reg
        && rel_cnt_reg == 4'h0);
    assign bus_release = in_seq;
    assign dev_reset_accept = dev_reset_cmd && !in_seq;
    assign dasp_n_out = 1'b0;
    assign pdiag_n_out = 1'b0;
    assign pdiag_n_oe = pdiag_drive_reg;
endmodule

// [prs_seq_chk.sv]
/*
 * Port-level assertions for the reset sequencer, bound into prs_seq.
 * Assumes one ref_clk domain and srst synchronous, active high.
 */
`timescale 1ns/1ps
`include "pata_rst_cfg.svh"
module prs_seq_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reset_n_pin,
    input wire logic is_dev1,
    input wire logic packet_dev,
    input wire logic srst_bit,
    input wire logic diag_pass,
    input wire logic bsy,
    input wire logic [7:0] status_clr,
    input wire logic bus_release,
    input wire logic udma_disable,
    input wire logic selected,
    input wire logic dev_reset_accept,
    input wire logic dasp_n_oe,
    input wire logic pdiag_n_oe,
    input wire logic done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // =====================================================
    // Sequences
    // =====================================================
    sequence sr_entry_dev0;
        $rose(srst_bit) && !is_dev1;
    endsequence
    sequence finish_dev1;
        done && is_dev1;
    endsequence

    // =====================================================
    // Assertions
    // =====================================================
    a_busy_answer: assert property ($rose(srst_bit) |-> ##[1:8] bsy)
        else $error("busy not raised within 400 ns of the reset request");
    a_bus_release: assert property (sr_entry_dev0 |-> ##[1:8] (bus_release && !pdiag_n_oe))
        else $error("bus not released within 400 ns");
    a_refuse_cmd: assert property (bsy |-> !dev_reset_accept)
        else $error("device reset command accepted while busy");
    a_done_idle: assert property (done |-> !bsy)
        else $error("busy still set at sequence end");
    a_status_mask: assert property (status_clr != 8'h00 |->
        status_clr == (packet_dev ? `PRS_ST_PKT_CLR : `PRS_ST_NONPKT_CLR))
        else $error("wrong status clear mask");
    a_select_end: assert property (done |=> (selected == !is_dev1))
        else $error("selection wrong after sequence end");
    a_pdiag_pass: assert property (finish_dev1 |=> (pdiag_n_oe == $past(diag_pass)))
        else $error("pass line does not follow the diagnostic result");
    a_dasp_assert: assert property ($rose(reset_n_pin) && is_dev1 |-> ##[1:1000] dasp_n_oe)
        else $error("activity line not asserted after reset release");
    a_udma_keep: assert property (srst_bit && reset_n_pin |-> !udma_disable)
        else $error("ultra dma disabled by software reset");
    a_busy_hold: assert property ($fell(srst_bit) |-> bsy)
        else $error("busy dropped while software reset runs");
endmodule

bind prs_seq prs_seq_chk u_chk (
    .ref_clk(ref_clk), .srst(srst), .reset_n_pin(reset_n_pin), .is_dev1(is_dev1),
    .packet_dev(packet_dev), .srst_bit(srst_bit), .diag_pass(diag_pass), .bsy(bsy),
    .status_clr(status_clr), .bus_release(bus_release), .udma_disable(udma_disable),
    .selected(selected), .dev_reset_accept(dev_reset_accept), .dasp_n_oe(dasp_n_oe),
    .pdiag_n_oe(pdiag_n_oe), .done(done)
);

// [prs_peer.sv]
/*
 * Behavioural second device on the activity and pass lines.
 * Assumes open-drain pins with pull-ups resolved by the bench.
 */
`timescale 1ns/1ps
module prs_peer #(
    parameter int DASP_DLY = 40,
    parameter int DIAG_DLY = 300
) (
    input wire logic ref_clk,
    input wire logic present,
    input wire logic reset_n,
    input wire logic srst_bit,
    input wire logic pass,
    output logic dasp_oe,
    output logic pdiag_oe
);
    logic [15:0] cnt_reg;
    logic hw_reg;
    always_ff @(posedge ref_clk) begin
        if (!present || !reset_n) begin
            dasp_oe <= 1'b0;
            pdiag_oe <= 1'b0;
            cnt_reg <= 16'h0000;
            hw_reg <= 1'b1;
        end else if (srst_bit) begin
            pdiag_oe <= 1'b0;
            cnt_reg <= 16'h0000;
            hw_reg <= 1'b0;
        end else begin
            if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
            if (hw_reg && cnt_reg == 16'(DASP_DLY)) dasp_oe <= 1'b1;
            if (cnt_reg == 16'(DIAG_DLY)) pdiag_oe <= pass;
        end
    end
endmodule

// [parallel_ata_reset_protocol_test.sv]
/*
 * Self-checking bench for prs_seq with a second device model.
 * Assumes 20 MHz ref_clk and pull-ups on the shared open-drain lines.
 */
`timescale 1ns/1ps
module parallel_ata_reset_protocol_test;
    logic ref_clk = 0, srst = 1, reset_n_pin = 1, is_dev1 = 0, packet_dev = 0, srst_bit = 0;
    logic dev_reset_cmd = 0, diag_done = 0, diag_pass = 1, mode_saved = 0, peer_on = 0;
    logic [6:0] diag_code = 7'h25;
    logic bsy, error_load, dev_bit_clr, srst_bit_clr, sig_load, word93_set, udma_disable;
    logic defaults_revert, modes_init, mode_restore_saved, mode_restore_default, diag_start;
    logic bus_release, selected, dev_reset_accept, dasp_n_oe, pdiag_n_oe, done, p_dasp, p_pdiag;
    logic [7:0] status_clr, error_val, sc, ev;
    logic [9:0] seen;
    int err_total = 0, n_tests = 0, cyc = 0, wt;
    wire dasp_n_pin = ~(dasp_n_oe | p_dasp);
    wire pdiag_n_pin = ~(pdiag_n_oe | p_pdiag);

    always #25 ref_clk = ~ref_clk;

    prs_seq DUT (.ref_clk(ref_clk), .srst(srst), .reset_n_pin(reset_n_pin), .is_dev1(is_dev1),
        .packet_dev(packet_dev), .srst_bit(srst_bit), .dev_reset_cmd(dev_reset_cmd),
        .dasp_n_in(dasp_n_pin), .pdiag_n_in(pdiag_n_pin), .diag_done(diag_done),
        .diag_pass(diag_pass), .diag_code(diag_code), .mode_saved(mode_saved), .bsy(bsy),
        .status_clr(status_clr), .error_val(error_val), .error_load(error_load),
        .dev_bit_clr(dev_bit_clr), .srst_bit_clr(srst_bit_clr), .sig_load(sig_load),
        .word93_set(word93_set), .udma_disable(udma_disable), .defaults_revert(defaults_revert),
        .modes_init(modes_init), .mode_restore_saved(mode_restore_saved),
        .mode_restore_default(mode_restore_default), .diag_start(diag_start),
        .bus_release(bus_release), .selected(selected), .dev_reset_accept(dev_reset_accept),
        .dasp_n_out(), .dasp_n_oe(dasp_n_oe), .pdiag_n_out(), .pdiag_n_oe(pdiag_n_oe), .done(done));

    prs_peer PEER (.ref_clk(ref_clk), .present(peer_on), .reset_n(reset_n_pin),
        .srst_bit(srst_bit), .pass(1'b1), .dasp_oe(p_dasp), .pdiag_oe(p_pdiag));

    // =====================================================
    // Helpers
    // =====================================================
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task check(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task sample;
        step(1);
        if (status_clr !== 8'h00) sc = status_clr;
        if (error_load === 1'b1) ev = error_val;
        seen |= {udma_disable, defaults_revert, diag_start, dev_bit_clr, word93_set,
            srst_bit_clr, sig_load, modes_init, mode_restore_saved, mode_restore_default};
    endtask

    // Counts cycles to the done pulse and gathers the finish pulses
    task wait_done(input int lim);
        sc = 8'h00;
        ev = 8'h00;
        seen = 10'h000;
        wt = 0;
        while (done !== 1'b1 && wt < lim) begin
            sample();
            wt++;
        end
        check(wt < lim, "sequence did not finish");
        sample();
        sample();
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // =====================================================
    // Scenarios
    // =====================================================
    task t_hw_dev0;
        peer_on = 1;
        reset_n_pin = 0;
        step(500);
        reset_n_pin = 1;
        diag_done = 1;
        wait_done(30000);
        check(selected === 1'b1 && bsy === 1'b0, "device 0 not idle and selected");
        check(sc === 8'h0D, "status mask wrong");
        $display("t_hw_dev0 finished");
    endtask

    task t_sr_dev0;
        packet_dev = 1;
        srst_bit = 1;
        step(8);
        check(bsy === 1'b1 && bus_release === 1'b1 && pdiag_n_oe === 1'b0, "bus not released");
        dev_reset_cmd = 1;
        step(1);
        check(dev_reset_accept === 1'b0, "command accepted while busy");
        dev_reset_cmd = 0;
        step(100);
        srst_bit = 0;
        step(15000);
        srst_bit = 1;
        step(100);
        srst_bit = 0;
        wait_done(40000);
        check(wt >= 20000 && seen[6] === 1'b1, "left the wait state early or did not restart");
        check(ev === {1'b0, diag_code}, "error value wrong");
        check(sc === 8'h7D && seen[2] === 1'b1 && seen[0] === 1'b1, "packet restore wrong");
        check(seen[8] === 1'b0, "packet device reverted to defaults");
        check(selected === 1'b1 && bsy === 1'b0, "device 0 not idle");
        $display("t_sr_dev0 finished");
    endtask

    task t_hw_dev1;
        peer_on = 0;
        is_dev1 = 1;
        mode_saved = 1;
        diag_done = 0;
        srst_bit = 1;
        step(100);
        reset_n_pin = 0;
        step(10);
        srst_bit = 0;
        step(490);
        reset_n_pin = 1;
        diag_done = 1;
        wait_done(2000);
        check(dasp_n_oe === 1'b1 && dasp_n_pin === 1'b0 && seen[6] === 1'b1, "activity or dev bit");
        check(seen[9] === 1'b1 && seen[7] === 1'b1, "ultra dma or diagnostics not started");
        check(seen[5] === 1'b1 && ev === {1'b0, diag_code}, "word 93 or error value");
        check(seen[4] === 1'b1 && seen[3] === 1'b1, "signature or reset bit clear");
        check(sc === 8'h7D && seen[1] === 1'b1 && seen[2] === 1'b1, "saved modes");
        check(pdiag_n_oe === 1'b1 && selected === 1'b0 && bsy === 1'b0, "device 1 finish");
        $display("t_hw_dev1 finished");
    endtask

    task t_sr_dev1;
        packet_dev = 0;
        diag_pass = 0;
        diag_done = 0;
        diag_code = 7'h51;
        check(bsy === 1'b0, "software reset requested while busy");
        srst_bit = 1;
        step(1);
        check(diag_start === 1'b1 && defaults_revert === 1'b1, "diagnostics not started on reset");
        step(99);
        srst_bit = 0;
        diag_done = 1;
        wait_done(2000);
        check(pdiag_n_oe === 1'b0 && pdiag_n_pin === 1'b1, "pass line on failure");
        check(sc === 8'h0D && ev === {1'b0, diag_code}, "status or error");
        check(seen[9] === 1'b0 && selected === 1'b0, "ultra dma touched or selected");
        $display("t_sr_dev1 finished");
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            $display("[FAIL] %0t run timed out", $time);
            wrap_up();
        end
    end

    initial begin
        step(5);
        srst = 0;
        step(2);
        t_hw_dev0();
        t_sr_dev0();
        t_hw_dev1();
        t_sr_dev1();
        wrap_up();
    end
endmodule
